/* File: design/aif_top.sv */
// Axis interrupt factor logic: four axes of cause registers, summary flags and the request pin
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - A detected error on an axis sets its error cause bit.
// - Any error cause bit set can pull the request pin low.
// - Error cause write command B2h clears bits written one, keeps zeros.
// - Error cause read command F2h clears register unless cause read-clear bit 23 set.
// - Read-clear command clears all bits, including ones seen by earlier direct reads.
// - Main status bit 4 is one while any error cause bit is one.
// - An enabled event sets its event cause bit.
// - Any event cause bit set can pull the request pin low.
// - Event cause write command B3h clears bits written one from I/O buffer.
// - Event cause read command F3h clears register only when bit 23 is zero.
// - Main status bit 5 is one while any event cause bit is one.
// - Stop with enable bit 27 sets stop flag status bit 2; else stays zero.
// - Stop flag set can pull the request pin low.
// - Command 2Dh clears the stop flag in any read-clear mode.
// - With bit 25 zero, main status read clears stop flag within three cycles.
// - Auxiliary flag follows same read-clear mode; command 2Eh clears it.
// - Mask bit 7 with pre-register state 10b or 11b blocks stop flag.
// - Normal and abnormal stops set stop flag alike; normal also sets event.
// - Request pin stays low until every cause on every unmasked axis clears.
// - Output mask bit 29 keeps its own axis off the pin without touching status.
module aif_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [4*aif_pkg::CAUSE_W-1:0] error_detect,
    input wire logic [4*aif_pkg::CAUSE_W-1:0] event_detect,
    input wire logic [3:0] op_stop,
    input wire logic [3:0] op_stop_abnormal,
    input wire logic [7:0] preregister_state,
    input wire logic [3:0] aux_status_set,
    output logic irq_n
);
    localparam int NA = aif_pkg::NUM_AXES;

    // ------------------------------------------------------------
    // Bus slave: address phase capture
    // ------------------------------------------------------------
    logic dp_valid;
    logic dp_write;
    logic [1:0] dp_axis;
    logic [5:0] dp_ofs;
    logic addr_ok;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_axis <= 2'h0;
            dp_ofs <= 6'h00;
        end else if (hready) begin
            dp_valid <= hsel && htrans[1];
            dp_write <= hwrite;
            dp_axis <= haddr[7:6];
            dp_ofs <= haddr[5:0];
        end
    end

    assign addr_ok = (dp_ofs <= aif_pkg::OFS_IRQ_CTRL) && (dp_ofs[1:0] == 2'h0);

    logic wr_en;
    logic rd_en;
    assign wr_en = dp_valid && dp_write && addr_ok;
    assign rd_en = dp_valid && !dp_write && addr_ok;
    logic rd_capture;
    assign rd_capture = rd_en && !hreadyout;

    // Writes are zero-wait; reads take one wait state so that hrdata can come from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= !(hready && hsel && htrans[1] && !hwrite);
            hresp <= 1'b0;
        end
    end

    AST_RD_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
        !hreadyout |=> hreadyout)
        else $error("read wait state longer than one cycle");

    // ------------------------------------------------------------
    // Per-axis state
    // ------------------------------------------------------------
    logic [31:0] io_buffer [NA];
    logic [31:0] error_cause_reg [NA];
    logic [31:0] event_cause_reg [NA];
    logic [31:0] event_enable_reg [NA];
    logic [31:0] env_config_two [NA];
    logic [31:0] env_config_five [NA];
    logic [31:0] operation_mode_reg [NA];
    logic [NA-1:0] irq_output_mask;
    logic [NA-1:0] stop_irq_flag;
    logic [NA-1:0] aux_status_flag;
    logic [NA-1:0] axis_req;
    logic [NA-1:0] cmd_hit;
    logic [NA-1:0] status_read;
    logic [7:0] cmd_code;

    assign cmd_code = hwdata[7:0];

    genvar g;
    generate
        for (g = 0; g < NA; g++) begin : gen_axis
            logic sel;
            logic cause_rc;
            logic main_rc;
            logic stop_set;
            logic [31:0] ev_in;
            logic [1:0] pre_state;

            assign sel = (dp_axis == 2'(g));
            assign cmd_hit[g] = wr_en && sel && (dp_ofs == aif_pkg::OFS_COMMAND);
            assign status_read[g] = rd_capture && sel && (dp_ofs == aif_pkg::OFS_MAIN_STATUS);
            assign cause_rc = !env_config_five[g][aif_pkg::BIT_CAUSE_READ_CLEAR];
            assign main_rc = !env_config_five[g][aif_pkg::BIT_MAIN_READ_CLEAR];
            assign pre_state = preregister_state[2*g +: 2];
            // Continuous operation masks the stop flag when pre-register is loaded
            assign stop_set = op_stop[g]
                && env_config_two[g][aif_pkg::BIT_STOP_IRQ_ENABLE]
                && !(operation_mode_reg[g][aif_pkg::BIT_CONT_STOP_MASK] && pre_state[1]);
            // Normal stop also reported as an event; abnormal stop only via stop flag
            assign ev_in = (event_detect[g*32 +: 32] & event_enable_reg[g])
                | (32'(op_stop[g] && !op_stop_abnormal[g]
                       && event_enable_reg[g][aif_pkg::BIT_NORMAL_STOP_EVENT])
                   << aif_pkg::BIT_NORMAL_STOP_EVENT);

            // Configuration registers
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    io_buffer[g] <= aif_pkg::RESET_WORD;
                    event_enable_reg[g] <= aif_pkg::RESET_WORD;
                    env_config_two[g] <= aif_pkg::RESET_WORD;
                    env_config_five[g] <= aif_pkg::RESET_WORD;
                    operation_mode_reg[g] <= aif_pkg::RESET_WORD;
                    irq_output_mask[g] <= 1'b0;
                end else if (wr_en && sel) begin
                    case (dp_ofs)
                        aif_pkg::OFS_IO_BUFFER: io_buffer[g] <= hwdata;
                        aif_pkg::OFS_EVENT_ENABLE: event_enable_reg[g] <= hwdata;
                        aif_pkg::OFS_ENV_TWO: env_config_two[g] <= hwdata;
                        aif_pkg::OFS_ENV_FIVE: env_config_five[g] <= hwdata;
                        aif_pkg::OFS_OP_MODE: operation_mode_reg[g] <= hwdata;
                        aif_pkg::OFS_IRQ_CTRL: begin
                            irq_output_mask[g] <= hwdata[aif_pkg::BIT_IRQ_OUTPUT_MASK];
                        end
                        default: ;
                    endcase
                end
            end

            // Error causes: new detections win over any clear in the same cycle
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    error_cause_reg[g] <= aif_pkg::RESET_WORD;
                end else if (cmd_hit[g] && cmd_code == aif_pkg::CMD_ERROR_CAUSE_WRITE) begin
                    error_cause_reg[g] <= (error_cause_reg[g] & ~io_buffer[g])
                        | error_detect[g*32 +: 32];
                end else if (cmd_hit[g] && cmd_code == aif_pkg::CMD_ERROR_CAUSE_READ
                             && cause_rc) begin
                    error_cause_reg[g] <= error_detect[g*32 +: 32];
                end else begin
                    error_cause_reg[g] <= error_cause_reg[g] | error_detect[g*32 +: 32];
                end
            end

            // Event causes
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    event_cause_reg[g] <= aif_pkg::RESET_WORD;
                end else if (cmd_hit[g] && cmd_code == aif_pkg::CMD_EVENT_CAUSE_WRITE) begin
                    event_cause_reg[g] <= (event_cause_reg[g] & ~io_buffer[g]) | ev_in;
                end else if (cmd_hit[g] && cmd_code == aif_pkg::CMD_EVENT_CAUSE_READ
                             && cause_rc) begin
                    event_cause_reg[g] <= ev_in;
                end else begin
                    event_cause_reg[g] <= event_cause_reg[g] | ev_in;
                end
            end

            // Stop and auxiliary flags; read-clear acts once, as the read data is captured
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    stop_irq_flag[g] <= 1'b0;
                end else if (stop_set) begin
                    stop_irq_flag[g] <= 1'b1;
                end else if ((cmd_hit[g] && cmd_code == aif_pkg::CMD_STOP_FLAG_CLEAR)
                             || (status_read[g] && main_rc)) begin
                    stop_irq_flag[g] <= 1'b0;
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    aux_status_flag[g] <= 1'b0;
                end else if (aux_status_set[g]) begin
                    aux_status_flag[g] <= 1'b1;
                end else if ((cmd_hit[g] && cmd_code == aif_pkg::CMD_AUX_FLAG_CLEAR)
                             || (status_read[g] && main_rc)) begin
                    aux_status_flag[g] <= 1'b0;
                end
            end

            // Mask gates only the pin, never the stored causes
            assign axis_req[g] = !irq_output_mask[g]
                && ((|error_cause_reg[g]) || (|event_cause_reg[g])
                    || stop_irq_flag[g]);

            AST_STOP_SET: assert property (@(posedge hclk) disable iff (!hresetn)
                stop_set |=> stop_irq_flag[g])
                else $error("stop flag not set after enabled stop");
            AST_STOP_BLOCKED: assert property (@(posedge hclk) disable iff (!hresetn)
                !stop_irq_flag[g] && op_stop[g] && pre_state[1]
                && operation_mode_reg[g][aif_pkg::BIT_CONT_STOP_MASK]
                |=> !stop_irq_flag[g])
                else $error("stop flag set despite continuous-stop mask");
            AST_STOP_RC: assert property (@(posedge hclk) disable iff (!hresetn)
                status_read[g] && main_rc && !stop_set |-> ##[1:3] !stop_irq_flag[g])
                else $error("stop flag not cleared by status read");
            AST_STOP_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
                stop_irq_flag[g] && !main_rc && !cmd_hit[g] |=> stop_irq_flag[g])
                else $error("stop flag lost without clear");
            AST_STOP_CMD: assert property (@(posedge hclk) disable iff (!hresetn)
                cmd_hit[g] && cmd_code == aif_pkg::CMD_STOP_FLAG_CLEAR && !stop_set
                |=> !stop_irq_flag[g])
                else $error("stop flag not cleared by clear command");
            AST_AUX_CMD: assert property (@(posedge hclk) disable iff (!hresetn)
                cmd_hit[g] && cmd_code == aif_pkg::CMD_AUX_FLAG_CLEAR && !aux_status_set[g]
                |=> !aux_status_flag[g])
                else $error("auxiliary flag not cleared by clear command");
            AST_ERR_SET: assert property (@(posedge hclk) disable iff (!hresetn)
                |error_detect[g*32 +: 32]
                |=> (error_cause_reg[g] & $past(error_detect[g*32 +: 32]))
                    == $past(error_detect[g*32 +: 32]))
                else $error("detected error not latched");
            AST_ERR_READ: assert property (@(posedge hclk) disable iff (!hresetn)
                cmd_hit[g] && cmd_code == aif_pkg::CMD_ERROR_CAUSE_READ && cause_rc
                |=> error_cause_reg[g] == $past(error_detect[g*32 +: 32]))
                else $error("error cause not cleared by read command");
            AST_ERR_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
                cmd_hit[g] && cmd_code == aif_pkg::CMD_ERROR_CAUSE_WRITE
                |=> (error_cause_reg[g] & ~$past(error_detect[g*32 +: 32]))
                    == ($past(error_cause_reg[g]) & ~$past(io_buffer[g])
                        & ~$past(error_detect[g*32 +: 32])))
                else $error("error cause write-one-clear wrong");
            AST_EVT_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
                cmd_hit[g] && cmd_code == aif_pkg::CMD_EVENT_CAUSE_WRITE
                |=> (event_cause_reg[g] & ~$past(ev_in))
                    == ($past(event_cause_reg[g]) & ~$past(io_buffer[g])
                        & ~$past(ev_in)))
                else $error("event cause write-one-clear wrong");
            AST_EVT_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
                !cause_rc && !(cmd_hit[g] && cmd_code == aif_pkg::CMD_EVENT_CAUSE_WRITE)
                |=> (event_cause_reg[g] & $past(event_cause_reg[g]))
                    == $past(event_cause_reg[g]))
                else $error("event cause cleared while read-clear disabled");
        end
    endgenerate

    // ------------------------------------------------------------
    // Read data mux and summary flags
    // ------------------------------------------------------------
    logic [31:0] next_rdata;
    logic [31:0] status_word;

    always_comb begin
        status_word = aif_pkg::RESET_WORD;
        status_word[aif_pkg::BIT_STOP_FLAG] = stop_irq_flag[dp_axis];
        status_word[aif_pkg::BIT_AUX_FLAG] = aux_status_flag[dp_axis];
        status_word[aif_pkg::BIT_ERROR_SUMMARY] = |error_cause_reg[dp_axis];
        status_word[aif_pkg::BIT_EVENT_SUMMARY] = |event_cause_reg[dp_axis];
    end

    // Read data mux over the data phase; the flop below holds it for the bus
    always_comb begin
        next_rdata = aif_pkg::RESET_WORD;
        if (rd_en) begin
            case (dp_ofs)
                aif_pkg::OFS_IO_BUFFER: next_rdata = io_buffer[dp_axis];
                aif_pkg::OFS_MAIN_STATUS: next_rdata = status_word;
                aif_pkg::OFS_ERROR_CAUSE: next_rdata = error_cause_reg[dp_axis];
                aif_pkg::OFS_EVENT_CAUSE: next_rdata = event_cause_reg[dp_axis];
                aif_pkg::OFS_EVENT_ENABLE: next_rdata = event_enable_reg[dp_axis];
                aif_pkg::OFS_ENV_TWO: next_rdata = env_config_two[dp_axis];
                aif_pkg::OFS_ENV_FIVE: next_rdata = env_config_five[dp_axis];
                aif_pkg::OFS_OP_MODE: next_rdata = operation_mode_reg[dp_axis];
                aif_pkg::OFS_IRQ_CTRL: begin
                    next_rdata[aif_pkg::BIT_IRQ_OUTPUT_MASK] = irq_output_mask[dp_axis];
                end
                default: next_rdata = aif_pkg::RESET_WORD;
            endcase
        end
    end
    // Captured in the wait state, so a write just before the read is already visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= aif_pkg::RESET_WORD;
        end else if (rd_capture) begin
            hrdata <= next_rdata;
        end else begin
            hrdata <= aif_pkg::RESET_WORD;
        end
    end

    // A status read is captured in its wait state and shown in the cycle after
    sequence status_capture_seq;
        rd_capture && (dp_ofs == aif_pkg::OFS_MAIN_STATUS);
    endsequence

    AST_ERR_SUMMARY: assert property (@(posedge hclk) disable iff (!hresetn)
        status_capture_seq |=> hrdata[aif_pkg::BIT_ERROR_SUMMARY]
            == $past(|error_cause_reg[dp_axis]))
        else $error("error summary flag wrong");
    AST_EVT_SUMMARY: assert property (@(posedge hclk) disable iff (!hresetn)
        status_capture_seq |=> hrdata[aif_pkg::BIT_EVENT_SUMMARY]
            == $past(|event_cause_reg[dp_axis]))
        else $error("event summary flag wrong");

    // ------------------------------------------------------------
    // Interrupt request pin
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= !(|axis_req);
        end
    end

    AST_IRQ_FOLLOW: assert property (@(posedge hclk) disable iff (!hresetn)
        |axis_req |=> !irq_n)
        else $error("request pin not low with pending cause");
    AST_IRQ_MASKED: assert property (@(posedge hclk) disable iff (!hresetn)
        &irq_output_mask |=> irq_n)
        else $error("request pin low while all axes masked");
    AST_IRQ_IDLE: assert property (@(posedge hclk) disable iff (!hresetn)
        !(|axis_req) |=> irq_n)
        else $error("request pin low with no unmasked cause");
endmodule

/* File: design/aif_pkg.sv */
// Package: register map, field positions and command codes of the axis interrupt factor block
package aif_pkg;
    localparam int NUM_AXES = 4;
    localparam int CAUSE_W = 32;
    // Per-axis register stride and offsets (byte addresses)
    localparam logic [11:0] AXIS_STRIDE = 12'h040;
    localparam logic [5:0] OFS_COMMAND = 6'h00;
    localparam logic [5:0] OFS_IO_BUFFER = 6'h04;
    localparam logic [5:0] OFS_MAIN_STATUS = 6'h08;
    localparam logic [5:0] OFS_ERROR_CAUSE = 6'h0C;
    localparam logic [5:0] OFS_EVENT_CAUSE = 6'h10;
    localparam logic [5:0] OFS_EVENT_ENABLE = 6'h14;
    localparam logic [5:0] OFS_ENV_TWO = 6'h18;
    localparam logic [5:0] OFS_ENV_FIVE = 6'h1C;
    localparam logic [5:0] OFS_OP_MODE = 6'h20;
    localparam logic [5:0] OFS_IRQ_CTRL = 6'h24;
    // Command codes
    localparam logic [7:0] CMD_ERROR_CAUSE_WRITE = 8'hB2;
    localparam logic [7:0] CMD_ERROR_CAUSE_READ = 8'hF2;
    localparam logic [7:0] CMD_EVENT_CAUSE_WRITE = 8'hB3;
    localparam logic [7:0] CMD_EVENT_CAUSE_READ = 8'hF3;
    localparam logic [7:0] CMD_STOP_FLAG_CLEAR = 8'h2D;
    localparam logic [7:0] CMD_AUX_FLAG_CLEAR = 8'h2E;
    // Field positions
    localparam int BIT_CAUSE_READ_CLEAR = 23;
    localparam int BIT_MAIN_READ_CLEAR = 25;
    localparam int BIT_STOP_IRQ_ENABLE = 27;
    localparam int BIT_IRQ_OUTPUT_MASK = 29;
    localparam int BIT_CONT_STOP_MASK = 7;
    localparam int BIT_STOP_FLAG = 2;
    localparam int BIT_AUX_FLAG = 3;
    localparam int BIT_ERROR_SUMMARY = 4;
    localparam int BIT_EVENT_SUMMARY = 5;
    localparam int BIT_NORMAL_STOP_EVENT = 0;
    // Reset values
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

/* File: verif/aif_host_cpu.sv */
// Host processor model: sees the request pin as an edge-triggered interrupt input
`timescale 1ns/1ps
module aif_host_cpu (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic irq_n,
    output int irq_edges
);
    logic irq_q;
    // Edge trigger: a pin held low gives no second interrupt, so software must let it rise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b1;
            irq_edges <= 0;
        end else begin
            irq_q <= irq_n;
            if (irq_q && !irq_n) begin
                irq_edges <= irq_edges + 1;
            end
        end
    end
endmodule

/* File: verif/aif_top_tb.sv */
// Self-checking bench for the axis interrupt factor block
`timescale 1ns/1ps
module aif_top_tb;
    localparam logic [5:0] CM = aif_pkg::OFS_COMMAND;
    localparam logic [5:0] ST = aif_pkg::OFS_MAIN_STATUS;
    localparam logic [5:0] EC = aif_pkg::OFS_ERROR_CAUSE;
    localparam logic [5:0] VC = aif_pkg::OFS_EVENT_CAUSE;
    logic hclk, hresetn, hsel, hwrite, hready_w, hresp, irq_n;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [4*aif_pkg::CAUSE_W-1:0] error_detect, event_detect;
    logic [3:0] op_stop, op_stop_abnormal, aux_status_set;
    logic [7:0] preregister_state;
    int irq_edges, err_count, total_checks, e0;

    aif_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready_w), .hrdata(hrdata),
        .hreadyout(hready_w), .hresp(hresp), .error_detect(error_detect),
        .event_detect(event_detect), .op_stop(op_stop), .op_stop_abnormal(op_stop_abnormal),
        .preregister_state(preregister_state), .aux_status_set(aux_status_set), .irq_n(irq_n));
    aif_host_cpu host (.hclk(hclk), .hresetn(hresetn), .irq_n(irq_n), .irq_edges(irq_edges));

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // ----------------------------------------
    // Bus and stimulus tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pin(input logic exp);
        chk({31'h0, irq_n}, {31'h0, exp});
    endtask
    // One single AHB transfer; no wait count assumed, the watchdog cuts a hang
    task automatic bus(input logic w, input int ax, input logic [5:0] ofs,
        input logic [31:0] wd, output logic [31:0] rdat);
        hsel <= 1'b1;
        haddr <= {24'h000000, 2'(ax), ofs};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready_w !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready_w !== 1'b1);
        rdat = hrdata;
    endtask
    task automatic wr(input int ax, input logic [5:0] ofs, input logic [31:0] wd);
        bus(1'b1, ax, ofs, wd, rd);
    endtask
    task automatic rchk(input int ax, input logic [5:0] ofs, input logic [31:0] exp);
        bus(1'b0, ax, ofs, 32'h0000_0000, rd);
        chk(rd, exp);
    endtask
    // Cause write commands B2h and B3h take their clear mask from the I/O buffer, so it is loaded first
    task automatic cmd(input int ax, input logic [7:0] code, input logic [31:0] iob);
        wr(ax, aif_pkg::OFS_IO_BUFFER, iob);
        wr(ax, CM, {24'h000000, code});
    endtask
    task automatic pulse(input int ax, input logic [31:0] er, input logic [31:0] ev,
        input logic stp, input logic ab, input logic aux);
        error_detect[ax*32 +: 32] <= er;
        event_detect[ax*32 +: 32] <= ev;
        op_stop[ax] <= stp;
        op_stop_abnormal[ax] <= ab;
        aux_status_set[ax] <= aux;
        tick(1);
        error_detect <= '0;
        event_detect <= '0;
        op_stop <= 4'h0;
        op_stop_abnormal <= 4'h0;
        aux_status_set <= 4'h0;
        tick(3);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {error_detect, event_detect, op_stop, op_stop_abnormal, aux_status_set} = '0;
        preregister_state = 8'h00;
        err_count = 0;
        total_checks = 0;
        hsize = 3'h2;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        tick(1);
        chk({30'h0, irq_n, hresp}, 32'h0000_0002);
        for (int g = 0; g < 4; g++) begin
            pulse(g, 32'h0000_0021, 32'h0, 1'b0, 1'b0, 1'b0);
            rchk(g, EC, 32'h0000_0021);
            rchk(g, ST, 32'h0000_0010);
            pin(1'b0);
            cmd(g, aif_pkg::CMD_ERROR_CAUSE_WRITE, 32'h0000_0001);
            rchk(g, EC, 32'h0000_0020);
            pin(1'b0);
            cmd(g, aif_pkg::CMD_ERROR_CAUSE_WRITE, 32'h0000_0020);
            rchk(g, ST, 32'h0000_0000);
            tick(2);
            pin(1'b1);
        end
        $display("test error causes done");
        wr(1, aif_pkg::OFS_EVENT_ENABLE, 32'h0000_0101);
        pulse(1, 32'h0000_0004, 32'h0000_0300, 1'b0, 1'b0, 1'b0);
        rchk(1, VC, 32'h0000_0100);
        rchk(1, ST, 32'h0000_0030);
        rchk(1, EC, 32'h0000_0004);
        cmd(1, aif_pkg::CMD_EVENT_CAUSE_READ, 32'h0000_0000);
        cmd(1, aif_pkg::CMD_ERROR_CAUSE_READ, 32'h0000_0000);
        rchk(1, EC, 32'h0000_0000);
        rchk(1, VC, 32'h0000_0000);
        rchk(1, ST, 32'h0000_0000);
        wr(1, aif_pkg::OFS_ENV_FIVE, 32'h0080_0000);
        pulse(1, 32'h0000_0004, 32'h0000_0100, 1'b0, 1'b0, 1'b0);
        cmd(1, aif_pkg::CMD_ERROR_CAUSE_READ, 32'h0000_0000);
        cmd(1, aif_pkg::CMD_EVENT_CAUSE_READ, 32'h0000_0000);
        rchk(1, EC, 32'h0000_0004);
        rchk(1, VC, 32'h0000_0100);
        cmd(1, aif_pkg::CMD_EVENT_CAUSE_WRITE, 32'h0000_0100);
        cmd(1, aif_pkg::CMD_ERROR_CAUSE_WRITE, 32'h0000_0004);
        rchk(1, VC, 32'h0000_0000);
        rchk(1, EC, 32'h0000_0000);
        $display("test read-clear modes done");
        pulse(2, 32'h0, 32'h0, 1'b1, 1'b0, 1'b0);
        rchk(2, ST, 32'h0000_0000);
        wr(2, aif_pkg::OFS_ENV_TWO, 32'h0800_0000);
        wr(2, aif_pkg::OFS_EVENT_ENABLE, 32'h0000_0001);
        pulse(2, 32'h0, 32'h0, 1'b1, 1'b0, 1'b0);
        pin(1'b0);
        rchk(2, ST, 32'h0000_0024);
        rchk(2, ST, 32'h0000_0020);
        cmd(2, aif_pkg::CMD_EVENT_CAUSE_WRITE, 32'h0000_0001);
        pulse(2, 32'h0, 32'h0, 1'b1, 1'b1, 1'b0);
        rchk(2, ST, 32'h0000_0004);
        rchk(2, ST, 32'h0000_0000);
        pulse(2, 32'h0, 32'h0, 1'b1, 1'b1, 1'b0);
        wr(2, CM, {24'h000000, aif_pkg::CMD_STOP_FLAG_CLEAR});
        rchk(2, ST, 32'h0000_0000);
        wr(2, aif_pkg::OFS_ENV_FIVE, 32'h0200_0000);
        pulse(2, 32'h0, 32'h0, 1'b1, 1'b1, 1'b1);
        rchk(2, ST, 32'h0000_000C);
        rchk(2, ST, 32'h0000_000C);
        wr(2, CM, {24'h000000, aif_pkg::CMD_STOP_FLAG_CLEAR});
        rchk(2, ST, 32'h0000_0008);
        wr(2, CM, {24'h000000, aif_pkg::CMD_AUX_FLAG_CLEAR});
        rchk(2, ST, 32'h0000_0000);
        wr(2, aif_pkg::OFS_ENV_FIVE, 32'h0000_0000);
        pulse(2, 32'h0, 32'h0, 1'b0, 1'b0, 1'b1);
        rchk(2, ST, 32'h0000_0008);
        rchk(2, ST, 32'h0000_0000);
        wr(2, aif_pkg::OFS_OP_MODE, 32'h0000_0080);
        for (int s = 0; s < 4; s++) begin
            preregister_state <= {2'h0, 2'(s), 4'h0};
            pulse(2, 32'h0, 32'h0, 1'b1, 1'b1, 1'b0);
            rchk(2, ST, (s >= 2) ? 32'h0000_0000 : 32'h0000_0004);
        end
        $display("test stop flag done");
        pulse(1, 32'h0000_0001, 32'h0, 1'b0, 1'b0, 1'b0);
        pulse(3, 32'h0000_0001, 32'h0, 1'b0, 1'b0, 1'b0);
        e0 = irq_edges;
        wr(3, aif_pkg::OFS_IRQ_CTRL, 32'h2000_0000);
        tick(3);
        pin(1'b0);
        cmd(1, aif_pkg::CMD_ERROR_CAUSE_WRITE, 32'h0000_0001);
        tick(3);
        pin(1'b1);
        rchk(3, EC, 32'h0000_0001);
        rchk(3, ST, 32'h0000_0010);
        wr(3, aif_pkg::OFS_IRQ_CTRL, 32'h0000_0000);
        tick(3);
        pin(1'b0);
        chk(32'(irq_edges - e0), 32'h0000_0001);
        wr(0, 6'h3C, 32'hFFFF_FFFF);
        rchk(0, 6'h3C, 32'h0000_0000);
        chk({31'h0, hresp}, 32'h0000_0000);
        $display("test mask and bus done");
        test_done;
    end

    // Whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        test_done;
    end
endmodule
